// ### hw/pfsel_regs.vh
// Purpose: constants for the pin function select block
// Assumes: 32-bit Avalon-MM register bus, word addressed by byte offset
// Notes: all select fields reset to the primary function
`ifndef PFSEL_REGS_VH
`define PFSEL_REGS_VH
`define PFSEL_ADDR_W 4
// register byte offsets
`define PFSEL_OFS_FUNC 4'h0
`define PFSEL_OFS_CLOCK_OUTPUT_PIN 4'h4
`define PFSEL_OFS_GDIR 4'h8
`define PFSEL_OFS_GOUT 4'hc
`define PFSEL_NREG 4
// function register fields
`define PFSEL_B6_LSB 0
`define PFSEL_B7_LSB 2
`define PFSEL_B4_LSB 4
`define PFSEL_RST_BIT 6
`define PFSEL_JTAG_BIT 7
`define PFSEL_CKMODE_BIT 8
`define PFSEL_SWIRE_BIT 9
// two-bit selector codes for port B pins
`define PFSEL_SEL_GPIO 2'h0
`define PFSEL_SEL_ALT1 2'h1
`define PFSEL_SEL_ALT2 2'h2
// clock output source codes
`define PFSEL_CKO_OFF 2'h0
`define PFSEL_CKO_MSTR 2'h1
`define PFSEL_CKO_IPB 2'h2
`define PFSEL_CKO_OSC 2'h3
// reset values
`define PFSEL_FUNC_RST 32'h0000_0000
`define PFSEL_CLOCK_OUTPUT_PIN_RST 32'h0000_0000
`define PFSEL_GDIR_RST 32'h0000_0000
`define PFSEL_GOUT_RST 32'h0000_0000
// internal reset release delay in clock cycles
`define PFSEL_RST_CYCLES 16
`endif

// ### hw/pfsel_regfile.v
// Purpose: small register store with registered read data
// Assumes: one write or one read per cycle
// Notes: each word resets to its own value
`default_nettype none
module pfsel_regfile #(
  parameter N = 4,
  parameter AW = 2,
  parameter [N*32-1:0] RST = {N*32{1'b0}}
) (
  input wire i_clock,
  input wire i_reset_n,
  input wire i_we,
  input wire [AW-1:0] i_waddr,
  input wire [31:0] i_wdata,
  input wire [3:0] i_be,
  input wire [AW-1:0] i_raddr,
  output reg [31:0] o_rdata,
  output wire [N*32-1:0] o_all
);
  reg [31:0] mem_q [0:N-1];
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : w
      integer b;
      always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
          mem_q[g] <= RST[g*32 +: 32];
        end else if (i_we && i_waddr == g) begin
          for (b = 0; b < 4; b = b + 1) begin
            if (i_be[b]) begin
              mem_q[g][b*8 +: 8] <= i_wdata[b*8 +: 8];
            end
          end
        end
      end
      assign o_all[g*32 +: 32] = mem_q[g];
    end
  endgenerate
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= 32'h0000_0000;
    end else begin
      o_rdata <= mem_q[i_raddr];
    end
  end
endmodule
`default_nettype wire

// ### hw/pfsel_top.v
// Purpose: pin function select for shared pins and the reset pin
// Assumes: Avalon-MM slave, 100 MHz clock, pins synchronous to it
// Notes: reads take two cycles; writes one
// Summary of operation
// - after reset every pin takes primary function
// - each gpio bit has own direction
// - b6 pin: gpio default, clock input by mode
// - low reset pin holds chip in reset
// - internal reset released synchronously after fixed cycles
// - clock output picks off, master, bus, oscillator
// - serial transmit pin bidirectional in single wire
// - test pins default to test port, else port d
//
// Register access over Avalon-MM and the register addresses were left to the implementer.
`default_nettype none
`include "pfsel_regs.vh"
module pfsel_top #(
  parameter RST_CYCLES = `PFSEL_RST_CYCLES
) (
  input wire i_clock,
  input wire i_reset_n,
  input wire i_por_n,
  input wire i_watchdog_reset,
  input wire i_soft_reset,
  // avalon-mm slave
  input wire [`PFSEL_ADDR_W-1:0] i_address,
  input wire i_read,
  input wire i_write,
  input wire [31:0] i_writedata,
  input wire [3:0] i_byteenable,
  output wire [31:0] o_readdata,
  output wire o_waitrequest,
  output reg o_chip_reset_n,
  // clock sources for the clock output
  input wire i_master_system_clock,
  input wire i_peripheral_bus_clock,
  input wire i_oscillator_clock_unit,
  // peripheral sides
  input wire i_tx_data,
  output reg o_rx_data,
  input wire i_sda_out_n,
  output reg o_sda_in,
  input wire i_scl_out_n,
  output reg o_scl_in,
  input wire i_tmr0_out,
  input wire i_tmr0_oe,
  output reg o_tmr0_in,
  output reg o_external_clock_input,
  output wire o_clock_source_mode_bit,
  input wire i_tdo,
  input wire i_tdo_en,
  output reg o_tck,
  output reg o_tms,
  output reg o_tdi,
  // gpio input view, bit 7 down to 0: d1, d0, d3, d2, a7, b4, b7, b6
  output reg [7:0] o_gpio_in,
  // pins: b6, b7, b4, reset/a7, tck, tms, tdi, tdo
  input wire [7:0] i_pin,
  output reg [7:0] o_pin,
  output reg [7:0] o_pin_oe_n
);
  localparam P_B6 = 0;
  localparam P_B7 = 1;
  localparam P_B4 = 2;
  localparam P_RST = 3;
  localparam P_TCK = 4;
  localparam P_TMS = 5;
  localparam P_TDI = 6;
  localparam P_TDO = 7;

  // ****************************************
  // bus slave
  // ****************************************
  localparam [`PFSEL_NREG*32-1:0] RST_ALL = {`PFSEL_GOUT_RST,
    `PFSEL_GDIR_RST, `PFSEL_CLOCK_OUTPUT_PIN_RST, `PFSEL_FUNC_RST};
  reg rd_busy_q;
  reg rd_busy_d;
  wire [`PFSEL_NREG*32-1:0] regs;
  wire [31:0] func;
  wire [31:0] clock_output_pin;
  wire [31:0] gdir;
  wire [31:0] gout;
  wire [31:0] mem_rdata;
  wire known;
  assign known = (i_address[1:0] == 2'h0);
  assign o_waitrequest = i_read & ~rd_busy_q;
  assign o_readdata = (rd_busy_q && known) ? mem_rdata : 32'h0000_0000;
  always @* begin
    rd_busy_d = i_read & ~rd_busy_q;
  end
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rd_busy_q <= 1'b0;
    end else begin
      rd_busy_q <= rd_busy_d;
    end
  end
  // misaligned writes are dropped; registers sit on word offsets
  pfsel_regfile #(
    .N(`PFSEL_NREG),
    .AW(2),
    .RST(RST_ALL)
  ) u_regs (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_we(i_write & known),
    .i_waddr(i_address[3:2]),
    .i_wdata(i_writedata),
    .i_be(i_byteenable),
    .i_raddr(i_address[3:2]),
    .o_rdata(mem_rdata),
    .o_all(regs)
  );
  assign func = regs[31:0];
  assign clock_output_pin = regs[63:32];
  assign gdir = regs[95:64];
  assign gout = regs[127:96];

  // ****************************************
  // selections
  // ****************************************
  wire [1:0] sel_b6 = func[`PFSEL_B6_LSB +: 2];
  wire [1:0] sel_b7 = func[`PFSEL_B7_LSB +: 2];
  wire [1:0] sel_b4 = func[`PFSEL_B4_LSB +: 2];
  wire rst_gpio = func[`PFSEL_RST_BIT];
  wire jtag_gpio = func[`PFSEL_JTAG_BIT];
  wire ck_mode = func[`PFSEL_CKMODE_BIT];
  wire single_wire = func[`PFSEL_SWIRE_BIT];
  assign o_clock_source_mode_bit = ck_mode;

  // ****************************************
  // reset pin and internal reset release
  // ****************************************
  // pin reset only counts while the pin still holds its reset role
  wire ext_rst = ~i_pin[P_RST] & ~rst_gpio;
  wire any_rst = ext_rst | i_watchdog_reset | i_soft_reset;
  reg [15:0] rcnt_q;
  always @(posedge i_clock or negedge i_por_n) begin
    if (!i_por_n) begin
      rcnt_q <= 16'h0000;
      o_chip_reset_n <= 1'b0;
    end else if (any_rst) begin
      rcnt_q <= 16'h0000;
      o_chip_reset_n <= 1'b0;
    end else if (rcnt_q < RST_CYCLES[15:0]) begin
      rcnt_q <= rcnt_q + 16'h0001;
    end else begin
      o_chip_reset_n <= 1'b1;
    end
  end

  // clock output source selection
  function ck_pick;
    input [1:0] s;
    input m;
    input p;
    input o;
    begin
      case (s)
        `PFSEL_CKO_MSTR: ck_pick = m;
        `PFSEL_CKO_IPB: ck_pick = p;
        `PFSEL_CKO_OSC: ck_pick = o;
        default: ck_pick = 1'b0;
      endcase
    end
  endfunction
  wire ck_out = ck_pick(clock_output_pin[1:0], i_master_system_clock,
    i_peripheral_bus_clock, i_oscillator_clock_unit);

  // ****************************************
  // pin drive, registered outputs
  // ****************************************
  // gpio bit order: 0=b6 1=b7 2=b4 3=a7 4..7=d2,d3,d0,d1
  reg [7:0] pin_d;
  reg [7:0] oe_n_d;
  integer k;
  always @* begin
    for (k = 0; k < 8; k = k + 1) begin
      pin_d[k] = gout[k];
      oe_n_d[k] = ~gdir[k];
    end
    case (sel_b6)
      `PFSEL_SEL_ALT2: begin
        pin_d[P_B6] = 1'b0;
        oe_n_d[P_B6] = i_sda_out_n;
      end
      `PFSEL_SEL_ALT1: oe_n_d[P_B6] = 1'b1;
      default: ;
    endcase
    if (ck_mode) begin
      oe_n_d[P_B6] = 1'b1;
    end
    case (sel_b7)
      `PFSEL_SEL_ALT1: begin
        pin_d[P_B7] = i_tx_data;
        // single wire: line released while transmitting a one
        oe_n_d[P_B7] = single_wire & i_tx_data;
      end
      `PFSEL_SEL_ALT2: begin
        pin_d[P_B7] = 1'b0;
        oe_n_d[P_B7] = i_scl_out_n;
      end
      default: ;
    endcase
    case (sel_b4)
      `PFSEL_SEL_ALT1: begin
        pin_d[P_B4] = i_tmr0_out;
        oe_n_d[P_B4] = ~i_tmr0_oe;
      end
      `PFSEL_SEL_ALT2: begin
        pin_d[P_B4] = ck_out;
        oe_n_d[P_B4] = 1'b0;
      end
      default: ;
    endcase
    pin_d[P_RST] = 1'b0;
    oe_n_d[P_RST] = ~(rst_gpio & gdir[P_RST] & ~gout[P_RST]);
    if (!jtag_gpio) begin
      oe_n_d[P_TCK] = 1'b1;
      oe_n_d[P_TMS] = 1'b1;
      oe_n_d[P_TDI] = 1'b1;
      pin_d[P_TDO] = i_tdo;
      oe_n_d[P_TDO] = ~i_tdo_en;
    end
  end
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pin <= 8'h00;
      o_pin_oe_n <= 8'hff;
      o_gpio_in <= 8'h00;
      o_rx_data <= 1'b1;
      o_sda_in <= 1'b1;
      o_scl_in <= 1'b1;
      o_tmr0_in <= 1'b0;
      o_external_clock_input <= 1'b0;
      o_tck <= 1'b1;
      o_tms <= 1'b1;
      o_tdi <= 1'b1;
    end else begin
      o_pin <= pin_d;
      o_pin_oe_n <= oe_n_d;
      o_gpio_in <= i_pin;
      // peripherals see idle levels unless they own the pin
      o_rx_data <= (sel_b6 == `PFSEL_SEL_ALT1) ? i_pin[P_B6] :
        (single_wire && sel_b7 == `PFSEL_SEL_ALT1) ? i_pin[P_B7] : 1'b1;
      o_sda_in <= (sel_b6 == `PFSEL_SEL_ALT2) ? i_pin[P_B6] : 1'b1;
      o_scl_in <= (sel_b7 == `PFSEL_SEL_ALT2) ? i_pin[P_B7] : 1'b1;
      o_tmr0_in <= (sel_b4 == `PFSEL_SEL_ALT1) ? i_pin[P_B4] : 1'b0;
      o_external_clock_input <= ck_mode & i_pin[P_B6];
      o_tck <= jtag_gpio ? 1'b1 : i_pin[P_TCK];
      o_tms <= jtag_gpio ? 1'b1 : i_pin[P_TMS];
      o_tdi <= jtag_gpio ? 1'b1 : i_pin[P_TDI];
    end
  end
endmodule
`default_nettype wire

// ### tb/pfsel_top_asserts.sv
// Purpose: port timing checks for the pin function select block
// Assumes: one clock; pin outputs registered
// Notes: release count watches every chip reset cause
`default_nettype none
module pfsel_asserts #(
  parameter RST_CYCLES = 16
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_por_n,
  input wire logic i_watchdog_reset,
  input wire logic i_soft_reset,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic o_waitrequest,
  input wire logic o_chip_reset_n,
  input wire logic o_external_clock_input,
  input wire logic o_clock_source_mode_bit,
  input wire logic [7:0] o_gpio_in,
  input wire logic [7:0] i_pin,
  input wire logic [7:0] o_pin,
  input wire logic [7:0] o_pin_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // quiet time since last cause
  // ****
  int quiet_q;
  wire cause = !i_por_n || i_watchdog_reset || i_soft_reset || !i_pin[3];
  always @(posedge i_clock) quiet_q <= cause ? 0 : quiet_q + 1;
  sequence rd_start;
    i_read && o_waitrequest;
  endsequence
  rd_wait_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    rd_start |=> !o_waitrequest) else $error("read waits too long");
  wr_nowait_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    i_write |-> !o_waitrequest) else $error("write waited");
  rst_idle_a: assert property (@(posedge i_clock)
    !i_reset_n |-> o_pin_oe_n == 8'hff) else $error("pin driven in reset");
  por_hold_a: assert property (@(posedge i_clock)
    !i_por_n |-> !o_chip_reset_n) else $error("chip out of reset");
  wdog_hold_a: assert property (@(posedge i_clock)
    disable iff (!i_por_n) i_watchdog_reset |=> !o_chip_reset_n)
    else $error("watchdog ignored");
  rel_early_a: assert property (@(posedge i_clock)
    disable iff (!i_por_n) $rose(o_chip_reset_n) |->
    quiet_q inside {[RST_CYCLES:RST_CYCLES+1]}) else $error("release off");
  rel_late_a: assert property (@(posedge i_clock)
    disable iff (!i_por_n) quiet_q == RST_CYCLES + 2 |-> o_chip_reset_n)
    else $error("release late");
  open_drain_a: assert property (@(posedge i_clock)
    disable iff (!i_reset_n) !o_pin_oe_n[3] |-> !o_pin[3])
    else $error("reset pin driven high");
  ckin_copy_a: assert property (@(posedge i_clock)
    disable iff (!i_reset_n) 1'b1 |=> o_external_clock_input ==
    ($past(o_clock_source_mode_bit) && $past(i_pin[0])))
    else $error("clock input wrong");
  ckin_drv_a: assert property (@(posedge i_clock)
    disable iff (!i_reset_n) o_clock_source_mode_bit [*2] |-> o_pin_oe_n[0])
    else $error("clock input pin driven");
  gpio_view_a: assert property (@(posedge i_clock)
    disable iff (!i_reset_n) 1'b1 |=> o_gpio_in == $past(i_pin))
    else $error("gpio input stale");
endmodule
bind pfsel_top pfsel_asserts #(.RST_CYCLES(RST_CYCLES)) pfsel_asserts_inst (
  .i_clock(i_clock), .i_reset_n(i_reset_n), .i_por_n(i_por_n),
  .i_watchdog_reset(i_watchdog_reset), .i_soft_reset(i_soft_reset),
  .i_read(i_read), .i_write(i_write), .o_waitrequest(o_waitrequest),
  .o_chip_reset_n(o_chip_reset_n), .o_gpio_in(o_gpio_in),
  .o_external_clock_input(o_external_clock_input), .i_pin(i_pin),
  .o_clock_source_mode_bit(o_clock_source_mode_bit), .o_pin(o_pin),
  .o_pin_oe_n(o_pin_oe_n));
`default_nettype wire

// ### tb/tb_top.sv
// Purpose: directed test of the pin function select block
// Assumes: short release count; pull-ups on every pin
// Notes: pin level resolved from enables
`default_nettype none
`include "pfsel_regs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RC = 4;
  localparam [11:0] SRC = 12'h2a7;
  logic i_clock = 0, i_reset_n = 1, i_por_n = 1, wdog = 0, rd = 0, wr = 0;
  logic ms = 0, pb = 0, os = 0, tx = 1, tmr = 1, tdo = 0, tdo_en = 0;
  logic o_waitrequest, o_chip_reset_n, o_rx_data, ext_ck, mode, o_tck;
  logic [3:0] adr = 0;
  logic [31:0] wd = 0, o_readdata, rd_v;
  logic [7:0] ext = 8'hff, o_pin, o_pin_oe_n;
  wire [7:0] i_pin = (o_pin & ~o_pin_oe_n) | (ext & o_pin_oe_n);
  int n_errors = 0, checks = 0;
  always #5 i_clock = ~i_clock;
  pfsel_top #(.RST_CYCLES(RC)) pfsel_top_inst (.i_clock, .i_reset_n,
    .i_por_n, .i_watchdog_reset(wdog), .i_soft_reset(1'b0), .i_address(adr),
    .i_read(rd), .i_write(wr), .i_writedata(wd), .i_byteenable(4'hf),
    .o_readdata, .o_waitrequest, .o_chip_reset_n, .i_master_system_clock(ms),
    .i_peripheral_bus_clock(pb), .i_oscillator_clock_unit(os),
    .i_tx_data(tx), .o_rx_data, .i_sda_out_n(1'b1), .o_sda_in(),
    .i_scl_out_n(1'b1), .o_scl_in(), .i_tmr0_out(tmr), .i_tmr0_oe(1'b1),
    .o_tmr0_in(), .o_external_clock_input(ext_ck), .i_tdo(tdo),
    .o_clock_source_mode_bit(mode), .i_tdo_en(tdo_en), .o_tck, .o_tms(),
    .o_tdi(), .o_gpio_in(), .i_pin, .o_pin, .o_pin_oe_n);
  // ****
  // access tasks
  // ****
  task automatic results;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clock);
  endtask
  // held until waitrequest is low at a rising edge; data taken there
  task automatic bus(input logic w, input logic [3:0] a, input [31:0] d);
    int k;
    @(posedge i_clock);
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    k = 0;
    do begin
      @(posedge i_clock);
      k++;
    end while (o_waitrequest !== 1'b0 && k < 9);
    // pre-edge values: design updates land after this read
    rd_v = o_readdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (k == 9) begin
      n_errors++;
      results();
    end
  endtask
  // ****
  // tests
  // ****
  initial begin
    // falling edge at time 0 fires the asynchronous resets
    i_reset_n <= 1'b0;
    i_por_n <= 1'b0;
    repeat (6) @(posedge i_clock);
    i_reset_n <= 1'b1;
    i_por_n <= 1'b1;
    cyc(RC + 3);
    chk("chip", 1, o_chip_reset_n);
    chk("oe", 8'hff, o_pin_oe_n);
    for (int a = 0; a < 17; a += 4) begin
      bus(0, a[3:0] | (a == 16 ? 4'h2 : 4'h0), 0);
      chk("reg", 0, rd_v);
    end
    $display("reset test done");
    bus(1, `PFSEL_OFS_GDIR, 32'h0000_0005);
    bus(1, `PFSEL_OFS_GOUT, 32'h0000_0004);
    cyc(3);
    chk("dir", 4'b1010, {o_pin[2], o_pin_oe_n[2:0]});
    bus(1, `PFSEL_OFS_FUNC, 32'h0000_0020);
    for (int c = 0; c < 4; c++) begin
      @(posedge i_clock) {ms, pb, os} <= SRC[3*c +: 3];
      bus(1, `PFSEL_OFS_CLOCK_OUTPUT_PIN, c);
      cyc(3);
      chk("clock_output_pin", {c != 0, 1'b0}, {o_pin[2], o_pin_oe_n[2]});
    end
    bus(1, `PFSEL_OFS_FUNC, 32'h0000_0010);
    @(posedge i_clock) tmr <= 1'b0;
    cyc(3);
    chk("timer", 0, o_pin[2]);
    $display("port b4 test done");
    bus(1, `PFSEL_OFS_FUNC, 32'h0000_0204);
    @(posedge i_clock) tx <= 1'b0;
    cyc(3);
    chk("txlo", 0, {o_pin[1], o_pin_oe_n[1], o_rx_data});
    @(posedge i_clock) tx <= 1'b1;
    cyc(3);
    chk("txhi", 2'b11, {o_rx_data, o_pin_oe_n[1]});
    bus(1, `PFSEL_OFS_FUNC, 32'h0000_0100);
    @(posedge i_clock) begin
      ext[4] <= 1'b0;
      tdo <= 1'b1;
      tdo_en <= 1'b1;
    end
    cyc(3);
    chk("ckin", 3'b111, {mode, ext_ck, o_pin_oe_n[0]});
    chk("tap", 3'b010, {o_tck, o_pin[7], o_pin_oe_n[7]});
    bus(1, `PFSEL_OFS_FUNC, 32'h0000_0080);
    cyc(3);
    chk("portd", 2'b11, {o_tck, o_pin_oe_n[7]});
    $display("shared pin test done");
    @(posedge i_clock) ext[3] <= 1'b0;
    cyc(3);
    chk("rstpin", 0, o_chip_reset_n);
    @(posedge i_clock) ext[3] <= 1'b1;
    cyc(RC + 3);
    chk("rel", 1, o_chip_reset_n);
    bus(1, `PFSEL_OFS_FUNC, 32'h0000_0040);
    bus(1, `PFSEL_OFS_GDIR, 32'h0000_0008);
    bus(1, `PFSEL_OFS_GOUT, 32'h0000_0000);
    cyc(3);
    chk("a7", 3'b001, {o_pin[3], o_pin_oe_n[3], o_chip_reset_n});
    bus(1, `PFSEL_OFS_GOUT, 32'h0000_0008);
    @(posedge i_clock) wdog <= 1'b1;
    cyc(2);
    chk("wdog", 2'b10, {o_pin_oe_n[3], o_chip_reset_n});
    @(posedge i_clock) wdog <= 1'b0;
    cyc(RC + 3);
    chk("wrel", 1, o_chip_reset_n);
    $display("reset pin test done");
    results();
  end
endmodule
`default_nettype wire
